/* File: logic/startup_fault_sequencer.sv */
// Purpose: Start-up sequencing and short-circuit fault control of a
//          synchronous buck controller
// Assumes: Analog comparators report supply, enable, regulator and FET
//          drop levels; PWM comparator reports the end of high-side time
// Notes:   Each pin passes two flops, so a pin change reaches the
//          outputs at the third clock edge after it. A FET drop only
//          counts while the registered drive has that FET on; the
//          sense path lags the drive by two clocks, so very short
//          pulses are judged on part of their length only.
// Notes on behaviour
// R1 - Supply below lockout forces gate drives off
// R2 - Oscillator and sequence need supply and enable
// R3 - Enable low: shutdown, regulator turned off
// R4 - Floating enable counts as asserted
// R5 - Enable driver limits current, not stiff source
// R6 - Drive 400 mV on error output, 1 ms
// R7 - Then pull error output low 1 ms
// R8 - Soft-start and switching only after both phases; a hiccup restart runs only the pull-low phase, threshold kept
// R9 - Sampled current picks 280/200/100 mV threshold
// R10 - Drop over threshold in cycle: count up
// R11 - High-side over fixed limit ends pulse early
// R12 - No drop over threshold: count down
// R13 - Count of 7: fault, both drives off
// R14 - Wait 50 ms off, then restart; repeat
// R15 - Counter floors at zero, cleared on restart
`timescale 1ns/100ps
`default_nettype none
`include "sequencer_regs.svh"
module startup_fault_sequencer #(
   parameter int SAMPLE_CYCLES    = `SAMPLE_CYCLES,
   parameter int PRECOND_CYCLES   = `PRECOND_CYCLES,
   parameter int HICCUP_CYCLES    = `HICCUP_CYCLES,
   parameter int SW_PERIOD_CYCLES = `SW_PERIOD_CYCLES,
   parameter int FAULT_LIMIT      = `FAULT_LIMIT
) (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic                         supply_above_lockout,
   input  wire logic                         enable_above_on,
   input  wire logic                         enable_floating,
   input  wire logic                         internal_regulator_ok,
   input  wire logic                         isense_above_hi,
   input  wire logic                         isense_above_lo,
   input  wire sequencer_pkg::sense_t        fet_sense,
   output logic                              internal_regulator_en,
   output logic                              osc_en,
   output logic                              soft_start_en,
   output logic                              fault,
   output var sequencer_pkg::gate_drive_t    gate_drive,
   output var sequencer_pkg::comp_mode_t     comp_mode,
   output var sequencer_pkg::ilim_sel_t      short_circuit_threshold
);
   import sequencer_pkg::*;

   // -------------------------------------------------------------------
   // Sizes and elaboration checks
   // -------------------------------------------------------------------
   localparam int TMAX = (HICCUP_CYCLES > SAMPLE_CYCLES) ?
                         HICCUP_CYCLES : SAMPLE_CYCLES;
   localparam int TMX2 = (TMAX > PRECOND_CYCLES) ? TMAX : PRECOND_CYCLES;
   localparam int TW   = $clog2(TMX2 + 1);
   localparam int FW   = $clog2(FAULT_LIMIT + 1);

   if (SAMPLE_CYCLES < 1 || PRECOND_CYCLES < 1 || HICCUP_CYCLES < 1)
   begin : g_chk_time
      $error("startup_fault_sequencer: phase counts must be at least 1");
   end
   if (FAULT_LIMIT < 1) begin : g_chk_fault
      $error("startup_fault_sequencer: FAULT_LIMIT must be at least 1");
   end
   if (SW_PERIOD_CYCLES < 2) begin : g_chk_period
      $error("startup_fault_sequencer: SW_PERIOD_CYCLES must be >= 2");
   end

   typedef enum logic [2:0] {
      ST_SHUTDOWN,
      ST_WAIT_REG,
      ST_SAMPLE,
      ST_PRECOND,
      ST_RUN,
      ST_HICCUP
   } state_t;

   // -------------------------------------------------------------------
   // Pin synchronisation
   // -------------------------------------------------------------------
   localparam int NS = 10;
   logic [NS-1:0] raw_in;
   logic [NS-1:0] sync_in;

   assign raw_in = {supply_above_lockout, enable_above_on, enable_floating,
                    internal_regulator_ok, isense_above_hi, isense_above_lo,
                    fet_sense};

   sync2 #(
      .WIDTH (NS)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   (raw_in),
      .q   (sync_in)
   );

   wire    supply_ok_s = sync_in[9];
   wire    enable_on_s = sync_in[8];
   wire    enable_flt_s = sync_in[7];
   wire    reg_ok_s    = sync_in[6];
   wire    isense_hi_s = sync_in[5];
   wire    isense_lo_s = sync_in[4];
   sense_t sense_s;
   assign  sense_s     = sense_t'(sync_in[3:0]);

   // An undriven pin is pulled high internally
   wire    enable_req  = enable_on_s | enable_flt_s;          // R4

   // -------------------------------------------------------------------
   // State, timer and fault counter
   // -------------------------------------------------------------------
   state_t       state_reg;
   state_t       state_next;
   logic [TW-1:0] tmr_reg;
   logic [TW-1:0] tmr_next;
   logic [FW-1:0] fcnt_reg;
   logic [FW-1:0] fcnt_next;
   logic          hs_phase_reg;
   logic          hs_phase_next;
   logic          cycle_over_reg;
   logic          cycle_over_next;
   logic          tick;
   ilim_sel_t     ilim_next;
   gate_drive_t   gate_next;
   comp_mode_t    comp_next;

   wire tmr_done  = (tmr_reg == '0);
   wire running   = (state_reg == ST_RUN);

   period_tick #(
      .PERIOD (SW_PERIOD_CYCLES)
   ) u_period (
      .clk  (clk),
      .rst  (rst),
      .run  (running),
      .tick (tick)
   );

   // -------------------------------------------------------------------
   // Per-cycle short-circuit detection
   // -------------------------------------------------------------------
   // A drop is judged only while that FET is actually driven on
   // Drops seen after a FET turned off are ignored, not counted late
   wire over_now  = (gate_drive.hs & sense_s.hs_over_thr) |
                    (gate_drive.ls & sense_s.ls_over_thr);      // R10
   wire over_cyc  = cycle_over_reg | over_now;
   wire fcnt_top  = (fcnt_reg == FW'(FAULT_LIMIT - 1));
   wire fault_hit = running & tick & over_cyc & fcnt_top;      // R13
   wire hs_end    = sense_s.pwm_end | sense_s.hs_over_fixed;   // R11

   assign cycle_over_next = (!running || tick) ? 1'b0 : over_cyc;
   assign hs_phase_next   = !running ? 1'b0 :
                            tick     ? 1'b1 :
                            (hs_phase_reg & ~hs_end);            // R11

   always_comb
   begin
      fcnt_next = fcnt_reg;
      if (!running)
         fcnt_next = '0;                                       // R15
      else if (tick && over_cyc)
         fcnt_next = fcnt_reg + 1'b1;                          // R10
      else if (tick && fcnt_reg != '0)
         fcnt_next = fcnt_reg - 1'b1;                          // R12 R15
   end

   // -------------------------------------------------------------------
   // Sequence control
   // -------------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      tmr_next   = tmr_done ? '0 : tmr_reg - 1'b1;
      if (!enable_req)
         state_next = ST_SHUTDOWN;                             // R3
      else if (!supply_ok_s)
         state_next = ST_WAIT_REG;                             // R1
      else
         unique case (state_reg)
            ST_SHUTDOWN:
               state_next = ST_WAIT_REG;
            ST_WAIT_REG:
               if (reg_ok_s)
               begin
                  state_next = ST_SAMPLE;                      // R2 R6
                  tmr_next   = TW'(SAMPLE_CYCLES - 1);
               end
            ST_SAMPLE:
               if (tmr_done)
               begin
                  state_next = ST_PRECOND;                     // R7
                  tmr_next   = TW'(PRECOND_CYCLES - 1);
               end
            ST_PRECOND:
               if (tmr_done)
                  state_next = ST_RUN;                         // R8
            ST_RUN:
               if (fault_hit)
               begin
                  state_next = ST_HICCUP;                      // R13
                  tmr_next   = TW'(HICCUP_CYCLES - 1);
               end
            ST_HICCUP:
               if (tmr_done)
               begin
                  state_next = ST_PRECOND;                     // R14
                  tmr_next   = TW'(PRECOND_CYCLES - 1);
               end
            // Two codes are never entered; recover through shutdown
            default:
               state_next = ST_SHUTDOWN;
         endcase
   end

   // -------------------------------------------------------------------
   // Threshold and drive decode
   // -------------------------------------------------------------------
   // Threshold latched at the end of sampling; above hi 100 mV, above lo only 280 mV, below both 200 mV
   assign ilim_next = (state_reg == ST_SAMPLE && tmr_done) ?
                      (isense_hi_s ? ILIM_100MV :
                       isense_lo_s ? ILIM_280MV : ILIM_200MV) :
                      short_circuit_threshold;                 // R9

   // Gates only switch in run; any other state holds both low
   assign gate_next.hs = (state_next == ST_RUN) & hs_phase_next;  // R1 R13
   assign gate_next.ls = (state_next == ST_RUN) & running &
                         ~hs_phase_next;                          // R1 R13

   assign comp_next = (state_next == ST_SAMPLE)  ? COMP_DRIVE_400MV :
                      (state_next == ST_PRECOND) ? COMP_PULL_LOW :
                      COMP_RELEASE;                                // R6 R7

   // -------------------------------------------------------------------
   // Output next values
   // -------------------------------------------------------------------
   // Regulator needs only enable; the oscillator also needs the supply
   // Fault marks the whole hiccup wait, gates being held off meanwhile
   logic reg_en_next;
   logic osc_next;
   logic ss_next;
   logic fault_next;

   assign reg_en_next = (state_next != ST_SHUTDOWN);          // R3
   assign osc_next    = enable_req & supply_ok_s &
                        (state_next != ST_SHUTDOWN);          // R2
   assign ss_next     = (state_next == ST_RUN);               // R8
   assign fault_next  = (state_next == ST_HICCUP);            // R14

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg      <= ST_SHUTDOWN;
         tmr_reg        <= '0;
         fcnt_reg       <= '0;
         hs_phase_reg   <= 1'b0;
         cycle_over_reg <= 1'b0;
      end
      else
      begin
         state_reg      <= state_next;
         tmr_reg        <= tmr_next;
         fcnt_reg       <= fcnt_next;
         hs_phase_reg   <= hs_phase_next;
         cycle_over_reg <= cycle_over_next;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         internal_regulator_en   <= 1'b0;
         osc_en                  <= 1'b0;
         soft_start_en           <= 1'b0;
         fault                   <= 1'b0;
         gate_drive              <= '0;
         comp_mode               <= COMP_RELEASE;
         short_circuit_threshold <= ILIM_200MV;
      end
      else
      begin
         internal_regulator_en   <= reg_en_next;
         osc_en                  <= osc_next;
         soft_start_en           <= ss_next;
         fault                   <= fault_next;
         gate_drive              <= gate_next;
         comp_mode               <= comp_next;
         short_circuit_threshold <= ilim_next;
      end
   end

endmodule : startup_fault_sequencer
`default_nettype wire

/* File: logic/sequencer_regs.svh */
// Purpose: Timing counts and fixed limits of the start-up/fault sequencer
// Assumes: 40 MHz system clock
// Notes:   Times keep their own units; cycle counts derive from them
`ifndef SEQUENCER_REGS_SVH
`define SEQUENCER_REGS_SVH

// ----------------------------------------------------------------------
// Clock and time figures
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ       40000000
`define CLK_PER_US        (`CLK_FREQ_HZ / 1000000)
`define CLK_PER_MS        (`CLK_FREQ_HZ / 1000)
`define SAMPLE_TIME_US    1000
`define PRECOND_TIME_US   1000
`define HICCUP_TIME_MS    50
`define SW_FREQ_KHZ       600

// ----------------------------------------------------------------------
// Derived cycle counts
// ----------------------------------------------------------------------
`define SAMPLE_CYCLES     (`SAMPLE_TIME_US * `CLK_PER_US)
`define PRECOND_CYCLES    (`PRECOND_TIME_US * `CLK_PER_US)
`define HICCUP_CYCLES     (`HICCUP_TIME_MS * `CLK_PER_MS)
`define SW_PERIOD_CYCLES  (`CLK_FREQ_HZ / (`SW_FREQ_KHZ * 1000))

// ----------------------------------------------------------------------
// Fault counter
// ----------------------------------------------------------------------
`define FAULT_LIMIT       7

`endif

/* File: logic/sequencer_pkg.sv */
// Purpose: Types shared by the start-up/fault sequencer files
// Assumes: Nothing
// Notes:   Encodings are internal to the sequencer and its analog front end
package sequencer_pkg;

   // Short-circuit threshold chosen during sampling
   typedef enum logic [1:0] {
      ILIM_200MV,
      ILIM_280MV,
      ILIM_100MV
   } ilim_sel_t;

   // What the error-amplifier output is forced to
   typedef enum logic [1:0] {
      COMP_RELEASE,
      COMP_DRIVE_400MV,
      COMP_PULL_LOW
   } comp_mode_t;

   typedef struct packed {
      logic hs;
      logic ls;
   } gate_drive_t;

   // Comparator results from the power stage
   typedef struct packed {
      logic hs_over_thr;
      logic ls_over_thr;
      logic hs_over_fixed;
      logic pwm_end;
   } sense_t;

endpackage : sequencer_pkg

/* File: logic/sync2.sv */
// Purpose: Two-flop synchroniser for asynchronous levels
// Assumes: Inputs are slow levels, not multi-bit words
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   if (WIDTH < 1) begin : g_chk
      $error("sync2: WIDTH must be at least 1");
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_reg <= '0;
         q        <= '0;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : sync2
`default_nettype wire

/* File: logic/period_tick.sv */
// Purpose: Switching-period divider giving a one-cycle start pulse
// Assumes: Single clock domain
// Notes:   Restarts from zero whenever run drops, so a new run starts
//          with a pulse in its first cycle
`timescale 1ns/100ps
`default_nettype none
module period_tick #(
   parameter int PERIOD = 66
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic run,
   output logic      tick
);
   localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   wire           wrap = (cnt_reg == CW'(PERIOD - 1));

   if (PERIOD < 2) begin : g_chk
      $error("period_tick: PERIOD must be at least 2");
   end

   assign cnt_next = !run ? '0 : (wrap ? '0 : cnt_reg + 1'b1);
   assign tick     = run && (cnt_reg == '0);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end
endmodule : period_tick
`default_nettype wire

/* File: tb/power_stage_model.sv */
// Purpose: Behavioural power stage feeding the FET comparators
// Assumes: Comparators read no drop while their FET is off
// Notes:   Short kind is latched as each high-side pulse starts
`timescale 1ns/100ps
`default_nettype none
module power_stage_model
   import sequencer_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire gate_drive_t gate_drive,
   input  wire logic [1:0]  short_req,
   input  wire logic        fixed_req,
   input  wire logic        pwm_stuck,
   output var  sense_t      fet_sense
);
   logic [1:0] short_reg;
   logic [1:0] short_now;
   logic       hs_q;
   logic [3:0] hs_cnt;

   assign short_now = (gate_drive.hs && !hs_q) ? short_req : short_reg;
   // Over-drop only while the FET conducts
   assign fet_sense.hs_over_thr   = short_now[1] & gate_drive.hs;
   assign fet_sense.ls_over_thr   = short_now[0] & gate_drive.ls;
   assign fet_sense.hs_over_fixed = fixed_req & gate_drive.hs;
   assign fet_sense.pwm_end = gate_drive.hs && hs_cnt != 4'h0 && !pwm_stuck;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         short_reg <= 2'h0;
         hs_q      <= 1'b0;
         hs_cnt    <= 4'h0;
      end
      else
      begin
         short_reg <= short_now;
         hs_q      <= gate_drive.hs;
         hs_cnt    <= gate_drive.hs ? hs_cnt + 4'h1 : 4'h0;
      end
   end
endmodule : power_stage_model
`default_nettype wire

/* File: tb/startup_fault_sequencer_assertions.sv */
// Purpose: Port checks of the start-up/fault sequencer
// Assumes: Bound to every startup_fault_sequencer
// Notes:   Phase lengths allow one cycle of slack
`timescale 1ns/100ps
`default_nettype none
module startup_fault_sequencer_assertions
   import sequencer_pkg::*;
#(
   parameter int SAMPLE_CYCLES  = 20,
   parameter int PRECOND_CYCLES = 20,
   parameter int HICCUP_CYCLES  = 50
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        supply_above_lockout,
   input wire logic        enable_above_on,
   input wire logic        enable_floating,
   input wire sense_t      fet_sense,
   input wire logic        internal_regulator_en,
   input wire logic        osc_en,
   input wire logic        soft_start_en,
   input wire logic        fault,
   input wire gate_drive_t gate_drive,
   input wire comp_mode_t  comp_mode
);
   comp_mode_t mode_prev_reg;
   int         mode_cnt_reg;
   int         fault_cnt_reg;

   // Length of the phase that just ended
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mode_prev_reg <= COMP_RELEASE;
         mode_cnt_reg  <= 0;
         fault_cnt_reg <= 0;
      end
      else
      begin
         mode_prev_reg <= comp_mode;
         mode_cnt_reg  <= (comp_mode != mode_prev_reg) ? 1 : mode_cnt_reg + 1;
         fault_cnt_reg <= fault ? fault_cnt_reg + 1 : 0;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_lockout_gates_off: assert property (
      (!supply_above_lockout) [*7] |-> gate_drive == '0)
      else $error("gates on below lockout");
   a_lockout_no_osc: assert property (
      (!supply_above_lockout) [*6] |-> !osc_en)
      else $error("oscillator on below lockout");
   a_shutdown_all_off: assert property (
      (!enable_above_on && !enable_floating) [*6]
      |-> !internal_regulator_en && !osc_en && !soft_start_en)
      else $error("not shut down with enable low");
   a_float_starts: assert property (
      (enable_floating && supply_above_lockout) [*6]
      |-> internal_regulator_en && osc_en)
      else $error("floating enable did not start");
   a_sample_length: assert property (
      comp_mode == COMP_PULL_LOW && mode_prev_reg == COMP_DRIVE_400MV
      |-> mode_cnt_reg inside {[SAMPLE_CYCLES:SAMPLE_CYCLES+1]})
      else $error("sampling phase length wrong");
   a_precond_length: assert property (
      comp_mode == COMP_RELEASE && mode_prev_reg == COMP_PULL_LOW
      |-> mode_cnt_reg inside {[PRECOND_CYCLES:PRECOND_CYCLES+1]}
          && soft_start_en)
      else $error("precondition phase length wrong");
   a_run_loop_free: assert property (
      soft_start_en |-> comp_mode == COMP_RELEASE)
      else $error("error output forced in run");
   a_switch_in_run: assert property (
      $rose(gate_drive.hs) |-> soft_start_en || $past(soft_start_en))
      else $error("switching outside run");
   a_fixed_limit_cut: assert property (
      gate_drive.hs && fet_sense.hs_over_fixed |-> ##[1:5] !gate_drive.hs)
      else $error("high-side pulse not cut");
   a_fault_gates_off: assert property (
      fault |-> gate_drive == '0)
      else $error("gate on during fault");
   a_hiccup_length: assert property (
      !fault && $past(fault)
      |-> fault_cnt_reg inside {[HICCUP_CYCLES:HICCUP_CYCLES+1]})
      else $error("hiccup wait length wrong");
   a_restart_precond: assert property (
      $fell(fault) |-> ##[0:1] comp_mode == COMP_PULL_LOW)
      else $error("hiccup restart skipped precondition");
endmodule : startup_fault_sequencer_assertions
`default_nettype wire

bind startup_fault_sequencer startup_fault_sequencer_assertions #(
   .SAMPLE_CYCLES(SAMPLE_CYCLES), .PRECOND_CYCLES(PRECOND_CYCLES),
   .HICCUP_CYCLES(HICCUP_CYCLES)) i_checker (
   .clk(clk), .rst(rst), .supply_above_lockout(supply_above_lockout),
   .enable_above_on(enable_above_on), .enable_floating(enable_floating),
   .fet_sense(fet_sense), .internal_regulator_en(internal_regulator_en),
   .osc_en(osc_en), .soft_start_en(soft_start_en), .fault(fault),
   .gate_drive(gate_drive), .comp_mode(comp_mode));

/* File: tb/testbench.sv */
// Purpose: Self-checking bench of the start-up/fault sequencer
// Assumes: Shortened phase counts, 8-cycle switching period
// Notes:   Inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import sequencer_pkg::*;
   localparam int PER = 8;
   logic        clk, rst, sup, ena, flt_en, reg_ok, hi, lo;
   logic        fixed_req, stuck, hs_d, reg_en, osc, ss, fault;
   logic [1:0]  short_req, r;
   sense_t      sense;
   gate_drive_t gate;
   comp_mode_t  mode;
   ilim_sel_t   thr, kept;
   int          mismatches, check_count, exp_cnt;

   startup_fault_sequencer #(.SAMPLE_CYCLES(20), .PRECOND_CYCLES(20),
      .HICCUP_CYCLES(50), .SW_PERIOD_CYCLES(PER), .FAULT_LIMIT(7))
   i_startup_fault_sequencer (.clk(clk), .rst(rst),
      .supply_above_lockout(sup), .enable_above_on(ena),
      .enable_floating(flt_en), .internal_regulator_ok(reg_ok),
      .isense_above_hi(hi), .isense_above_lo(lo), .fet_sense(sense),
      .internal_regulator_en(reg_en), .osc_en(osc), .soft_start_en(ss),
      .fault(fault), .gate_drive(gate), .comp_mode(mode),
      .short_circuit_threshold(thr));

   power_stage_model i_power_stage_model (.clk(clk), .rst(rst),
      .gate_drive(gate), .short_req(short_req), .fixed_req(fixed_req),
      .pwm_stuck(stuck), .fet_sense(sense));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(negedge clk) reg_ok <= reg_en;
   always @(posedge clk) hs_d <= gate.hs;

   task automatic final_report;
      if (mismatches == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   task automatic chk_bit(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e)
      begin
         $display("MISMATCH %s exp %b got %b", n, e, g);
         mismatches++;
      end
   endtask : chk_bit

   task automatic chk_thr(input string n, input ilim_sel_t e,
                          input ilim_sel_t g);
      check_count++;
      if (g !== e)
      begin
         $display("MISMATCH %s exp %0d got %0d", n, e, g);
         mismatches++;
      end
   endtask : chk_thr

   function automatic logic probe(input int w);
      case (w)
         0: return ss;
         1: return gate.hs && !hs_d;
         2: return fault;
         default: return mode == COMP_PULL_LOW;
      endcase
   endfunction : probe

   task automatic wait_for(input int w, input int bound);
      int n;
      n = 0;
      @(negedge clk);
      while (probe(w) !== 1'b1)
      begin
         n++;
         if (n > bound)
         begin
            $display("MISMATCH wait_%0d exp 1 got 0", w);
            mismatches++;
            final_report();
         end
         @(negedge clk);
      end
   endtask : wait_for

   function automatic ilim_sel_t thr_of(input logic h, input logic l);
      return h ? ILIM_100MV : (l ? ILIM_280MV : ILIM_200MV);
   endfunction : thr_of

   function automatic int next_cnt(input int c, input logic over);
      return over ? c + 1 : (c > 0 ? c - 1 : 0);
   endfunction : next_cnt

   function automatic logic over_at(input int p);
      return (p >= 8 && p < 14) || (p >= 22 && p < 29);
   endfunction : over_at

   task automatic restart(input logic h, input logic l);
      ena = 1'b0;
      repeat (6) @(negedge clk);
      chk_bit("regulator_en", 1'b0, reg_en);
      chk_bit("osc_en", 1'b0, osc);
      hi = h;
      lo = l;
      ena = 1'b1;
      wait_for(3, 80);
      chk_thr("threshold", thr_of(h, l), thr);
      wait_for(0, 80);
   endtask : restart

   initial
   begin
      mismatches = 0;
      check_count = 0;
      rst = 1'b1;
      sup = 1'b1;
      ena = 1'b0;
      flt_en = 1'b0;
      hi = 1'b0;
      lo = 1'b0;
      short_req = 2'h0;
      fixed_req = 1'b0;
      stuck = 1'b0;
      void'($urandom(31));
      repeat (4) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         r = (i < 4) ? 2'(i) : 2'($urandom);
         restart(r[1], r[0]);
      end
      kept = thr_of(r[1], r[0]);
      exp_cnt = 0;
      for (int p = 0; p < 29; p++)
      begin
         wait_for(1, 3 * PER);
         exp_cnt = next_cnt(exp_cnt, p > 0 && over_at(p - 1));
         chk_bit("early_fault", 1'b0, fault);
         r = 2'($urandom);
         short_req = over_at(p) ? (r[0] ? 2'h2 : 2'h1) : 2'h0;
      end
      wait_for(2, 3 * PER);
      chk_bit("fault", next_cnt(exp_cnt, over_at(28)) >= 7, fault);
      chk_bit("gates_off", 1'b0, |gate);
      short_req = 2'h0;
      wait_for(0, 130);
      chk_thr("threshold_kept", kept, thr);
      fixed_req = 1'b1;
      stuck = 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         wait_for(1, 3 * PER);
         repeat (6) @(negedge clk);
         chk_bit("hs_cut", 1'b0, gate.hs);
      end
      fixed_req = 1'b0;
      stuck = 1'b0;
      sup = 1'b0;
      repeat (8) @(negedge clk);
      chk_bit("lockout_gates", 1'b0, |gate);
      chk_bit("lockout_osc", 1'b0, osc);
      chk_bit("lockout_regulator", 1'b1, reg_en);
      sup = 1'b1;
      wait_for(0, 100);
      ena = 1'b0;
      repeat (6) @(negedge clk);
      flt_en = 1'b1;
      wait_for(0, 150);
      final_report();
   end
endmodule : testbench
`default_nettype wire
